// *** rtl/pllcg_pkg.sv ***
// Types shared by the clock generator control block
package pllcg_pkg;
  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } pllcg_axi_req_s;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } pllcg_axi_rsp_s;
  typedef enum logic [2:0] {
    ST_RUN  = 3'b001,
    ST_STOP = 3'b010,
    ST_WAIT = 3'b100
  } pllcg_state_e;
endpackage : pllcg_pkg

// *** rtl/pllcg_regs.svh ***
// Register map, field positions, reset values and timing counts of the clock generator control
`ifndef PLLCG_REGS_SVH
`define PLLCG_REGS_SVH
// Byte addresses on the AXI4-Lite bus
`define PLLCG_ADDR_SYSCLK   32'h0000_0000
`define PLLCG_ADDR_LPWR     32'h0000_0004
// System clock control fields
`define PLLCG_SYS_PINOFF    7
`define PLLCG_SYS_SWMODE    3
`define PLLCG_SYS_BMSEL_HI  2
`define PLLCG_SYS_BMSEL_LO  0
// Low-power control fields
`define PLLCG_LP_RSV_HI     3
`define PLLCG_LP_RSV_LO     2
`define PLLCG_LP_MULT_HI    1
`define PLLCG_LP_MULT_LO    0
// Reset values
`define PLLCG_RST_BYTE      8'h00
`define PLLCG_RST_MULT      2'h0
`define PLLCG_RST_BMSEL     3'h0
// Multiplier codes and last phase of one system clock period
`define PLLCG_MULT_X1       2'h0
`define PLLCG_MULT_X2       2'h1
`define PLLCG_MULT_X4       2'h2
`define PLLCG_LAST_X1       3'h7
`define PLLCG_LAST_X2       3'h3
`define PLLCG_LAST_X4       3'h1
// Standby wait counts in clk cycles, one per wait select code
`define PLLCG_WAIT_CNT0     13'h0040
`define PLLCG_WAIT_CNT1     13'h0080
`define PLLCG_WAIT_CNT2     13'h0100
`define PLLCG_WAIT_CNT3     13'h0200
`define PLLCG_WAIT_CNT4     13'h0400
`define PLLCG_WAIT_CNT5     13'h0800
`define PLLCG_WAIT_CNT6     13'h1000
`define PLLCG_WAIT_CNT7     13'h1000
// AXI responses
`define PLLCG_RESP_OKAY     2'h0
`define PLLCG_RESP_SLVERR   2'h2
`endif

// *** rtl/pllcg_top.sv ***
// Clock generator control: multiplier, bus clock divider, clock pin and standby sequencing
//
// How it works
// - The clock pin shows the system clock unless output-off is set, is high in software standby and floats in hardware standby.
// - Bits 6 to 4 of the system clock control register always read as zero.
// - With switch mode 0 a new multiplier waits for a pass through software standby.
// - With switch mode 1 a new multiplier is applied at the next system clock period end after it is written.
// - The bus clock select gives full speed for 000 and the system clock over 2 to 32 for 001 to 101, with 11X prohibited.
// - The multiplier field gives x1, x2 or x4 for 00, 01, 10, with 11 prohibited.
// - Bits 3 and 2 of the low-power control register are plain storage that software keeps at zero.
// - After reset the multiplier is one.
// - Entering software standby stops the clock and makes the written multiplier active.
// - After standby release the chosen wait time is counted before the clock resumes.
// - The system clock phase is aligned to the rising edge of the external clock pin.
// - A break armed on the sleep instruction starts only after the stabilisation wait.
`timescale 1ns/1ps
`default_nettype none
`include "pllcg_regs.svh"
module pllcg_top (
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  input  wire pllcg_pkg::pllcg_axi_req_s axiReq,
  output var  pllcg_pkg::pllcg_axi_rsp_s axiRsp,
  input  wire logic                     extClkPin,
  input  wire logic                     hwStandbyPin,
  input  wire logic                     standbyEnter,
  input  wire logic                     standbyRelease,
  input  wire logic                     pcBreakOnSleep,
  input  wire logic [2:0]               standbyWaitSelect,
  output logic                          phiTick,
  output logic                          busTick,
  output logic                          phiPinOut,
  output logic                          phiPinOe,
  output logic                          clockRunning,
  output logic [1:0]                    activeMult,
  output logic                          breakStart
);
  import pllcg_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  pllcg_axi_rsp_s axiRsp_r;
  pllcg_state_e   state_r;
  logic [1:0]     pinSync1_r;
  logic [1:0]     pinSync2_r;
  logic           extPrev_r;
  logic           awHeld_r;
  logic           wHeld_r;
  logic [31:0]    awAddr_r;
  logic [31:0]    wData_r;
  logic           wStrb_r;
  logic           pinOff_r;
  logic           swMode_r;
  logic [2:0]     bmSel_r;
  logic [2:0]     bmAct_r;
  logic [1:0]     lpRsv_r;
  logic [1:0]     multReq_r;
  logic [1:0]     multAct_r;
  logic           multPend_r;
  logic           hwStop_r;
  logic           breakArm_r;
  logic [12:0]    waitCnt_r;
  logic [2:0]     phase_r;
  logic [4:0]     busCnt_r;
  logic           phiTick_r;
  logic           busTick_r;
  logic           phiPin_r;
  logic           phiOe_r;
  logic           running_r;
  logic           breakStart_r;
  logic           extSync;
  logic           hwStb;
  logic           extRise;
  logic           running;
  logic           wrFire;
  logic           wrSys;
  logic           wrLp;
  logic           phaseEnd;
  logic [2:0]     phaseLast;
  logic [2:0]     phase_nxt;
  logic           phiTick_nxt;
  logic [4:0]     busMask;
  logic           busEnd;
  logic [4:0]     busCnt_nxt;
  logic [12:0]    waitLoad;
  logic [31:0]    rdData;
  logic           rdHit;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Two flops per pin; only the second stage feeds logic
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pinSync1_r <= 2'h0;
      pinSync2_r <= 2'h0;
      extPrev_r  <= 1'b0;
    end else begin
      pinSync1_r <= {hwStandbyPin, extClkPin};
      pinSync2_r <= pinSync1_r;
      extPrev_r  <= pinSync2_r[0];
    end
  end

  assign extSync = pinSync2_r[0];
  assign hwStb   = pinSync2_r[1];
  assign extRise = extSync & ~extPrev_r;
  assign running = (state_r == ST_RUN);

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  // Address and data are taken in either order; the write fires once both are held
  assign wrFire = awHeld_r & wHeld_r & ~axiRsp_r.bvalid;
  assign wrSys  = wrFire & wStrb_r & (awAddr_r == `PLLCG_ADDR_SYSCLK);
  assign wrLp   = wrFire & wStrb_r & (awAddr_r == `PLLCG_ADDR_LPWR);

  // Write channels and response
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      awHeld_r         <= 1'b0;
      wHeld_r          <= 1'b0;
      awAddr_r         <= 32'h0000_0000;
      wData_r          <= 32'h0000_0000;
      wStrb_r          <= 1'b0;
      axiRsp_r.awready <= 1'b1;
      axiRsp_r.wready  <= 1'b1;
      axiRsp_r.bvalid  <= 1'b0;
      axiRsp_r.bresp   <= `PLLCG_RESP_OKAY;
    end else begin
      if (axiReq.awvalid && axiRsp_r.awready) begin
        awHeld_r         <= 1'b1;
        awAddr_r         <= {axiReq.awaddr[31:2], 2'b00};
        axiRsp_r.awready <= 1'b0;
      end
      if (axiReq.wvalid && axiRsp_r.wready) begin
        wHeld_r         <= 1'b1;
        wData_r         <= axiReq.wdata;
        wStrb_r         <= axiReq.wstrb[0];
        axiRsp_r.wready <= 1'b0;
      end
      if (wrFire) begin
        awHeld_r        <= 1'b0;
        wHeld_r         <= 1'b0;
        axiRsp_r.bvalid <= 1'b1;
        axiRsp_r.bresp  <= ((awAddr_r == `PLLCG_ADDR_SYSCLK) || (awAddr_r == `PLLCG_ADDR_LPWR)) ?
                           `PLLCG_RESP_OKAY : `PLLCG_RESP_SLVERR;
      end
      if (axiRsp_r.bvalid && axiReq.bready) begin
        axiRsp_r.bvalid  <= 1'b0;
        axiRsp_r.awready <= 1'b1;
        axiRsp_r.wready  <= 1'b1;
      end
    end
  end

  // Read data mux; reserved bits stay zero because nothing drives them
  always_comb begin
    rdData = 32'h0000_0000;
    rdHit  = 1'b1;
    if ({axiReq.araddr[31:2], 2'b00} == `PLLCG_ADDR_SYSCLK) begin
      rdData[`PLLCG_SYS_PINOFF]                       = pinOff_r;
      rdData[`PLLCG_SYS_SWMODE]                       = swMode_r;
      rdData[`PLLCG_SYS_BMSEL_HI:`PLLCG_SYS_BMSEL_LO] = bmSel_r;
    end else if ({axiReq.araddr[31:2], 2'b00} == `PLLCG_ADDR_LPWR) begin
      rdData[`PLLCG_LP_RSV_HI:`PLLCG_LP_RSV_LO]   = lpRsv_r;
      rdData[`PLLCG_LP_MULT_HI:`PLLCG_LP_MULT_LO] = multReq_r;
    end else begin
      rdHit = 1'b0;
    end
  end

  // Read channel: answer one cycle after the address is taken
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      axiRsp_r.arready <= 1'b1;
      axiRsp_r.rvalid  <= 1'b0;
      axiRsp_r.rdata   <= 32'h0000_0000;
      axiRsp_r.rresp   <= `PLLCG_RESP_OKAY;
    end else if (axiReq.arvalid && axiRsp_r.arready) begin
      axiRsp_r.arready <= 1'b0;
      axiRsp_r.rvalid  <= 1'b1;
      axiRsp_r.rdata   <= rdData;
      axiRsp_r.rresp   <= rdHit ? `PLLCG_RESP_OKAY : `PLLCG_RESP_SLVERR;
    end else if (axiRsp_r.rvalid && axiReq.rready) begin
      axiRsp_r.rvalid  <= 1'b0;
      axiRsp_r.arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Upper low-power bits are stored and read back; software keeps them zero anyway
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pinOff_r  <= 1'b0;
      swMode_r  <= 1'b0;
      bmSel_r   <= `PLLCG_RST_BMSEL;
      lpRsv_r   <= 2'h0;
      multReq_r <= `PLLCG_RST_MULT;
    end else begin
      if (wrSys) begin
        pinOff_r <= wData_r[`PLLCG_SYS_PINOFF];
        swMode_r <= wData_r[`PLLCG_SYS_SWMODE];
        bmSel_r  <= wData_r[`PLLCG_SYS_BMSEL_HI:`PLLCG_SYS_BMSEL_LO];
      end
      if (wrLp) begin
        lpRsv_r   <= wData_r[`PLLCG_LP_RSV_HI:`PLLCG_LP_RSV_LO];
        multReq_r <= wData_r[`PLLCG_LP_MULT_HI:`PLLCG_LP_MULT_LO];
      end
    end
  end

  // ----------------------------------------------------------------
  // Multiplier
  // ----------------------------------------------------------------
  // Prohibited code 11 runs as x1 rather than leaving the period undefined
  always_comb begin
    unique case (multAct_r)
      `PLLCG_MULT_X2: phaseLast = `PLLCG_LAST_X2;
      `PLLCG_MULT_X4: phaseLast = `PLLCG_LAST_X4;
      default:        phaseLast = `PLLCG_LAST_X1;
    endcase
  end

  assign phaseEnd = (phase_r == phaseLast);

  // Immediate changes wait for a period end; standby entry adopts the written value
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      multAct_r  <= `PLLCG_RST_MULT;
      multPend_r <= 1'b0;
    end else begin
      if (running && standbyEnter) begin
        multAct_r  <= multReq_r;
        multPend_r <= 1'b0;
      end else if (running && swMode_r && multPend_r && phaseEnd) begin
        multAct_r  <= multReq_r;
        multPend_r <= 1'b0;
      end
      if (wrLp && swMode_r) begin
        multPend_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Standby sequencer
  // ----------------------------------------------------------------
  // Wait table of fixed counts; standbyWaitSelect is sampled when standby is released
  always_comb begin
    unique case (standbyWaitSelect)
      3'h0:    waitLoad = `PLLCG_WAIT_CNT0;
      3'h1:    waitLoad = `PLLCG_WAIT_CNT1;
      3'h2:    waitLoad = `PLLCG_WAIT_CNT2;
      3'h3:    waitLoad = `PLLCG_WAIT_CNT3;
      3'h4:    waitLoad = `PLLCG_WAIT_CNT4;
      3'h5:    waitLoad = `PLLCG_WAIT_CNT5;
      3'h6:    waitLoad = `PLLCG_WAIT_CNT6;
      default: waitLoad = `PLLCG_WAIT_CNT7;
    endcase
  end

  // Run, stopped, and stabilisation wait
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r      <= ST_RUN;
      hwStop_r     <= 1'b0;
      breakArm_r   <= 1'b0;
      waitCnt_r    <= 13'h0000;
      breakStart_r <= 1'b0;
    end else begin
      breakStart_r <= 1'b0;
      unique case (state_r)
        ST_RUN: begin
          if (hwStb) begin
            state_r  <= ST_STOP;
            hwStop_r <= 1'b1;
          end else if (standbyEnter) begin
            state_r    <= ST_STOP;
            breakArm_r <= pcBreakOnSleep;
          end
        end
        ST_STOP: begin
          if (!hwStb && (hwStop_r || standbyRelease)) begin
            state_r   <= ST_WAIT;
            hwStop_r  <= 1'b0;
            waitCnt_r <= waitLoad;
          end
        end
        ST_WAIT: begin
          if (hwStb) begin
            state_r  <= ST_STOP;
            hwStop_r <= 1'b1;
          end else if (waitCnt_r <= 13'h0001) begin
            state_r      <= ST_RUN;
            breakStart_r <= breakArm_r;
            breakArm_r   <= 1'b0;
          end else begin
            waitCnt_r <= waitCnt_r - 13'h0001;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // System clock phase and bus clock divider
  // ----------------------------------------------------------------
  // Restart on the external edge keeps phase locked to the oscillator
  always_comb begin
    if (!running || extRise || phaseEnd) begin
      phase_nxt = 3'h0;
    end else begin
      phase_nxt = phase_r + 3'h1;
    end
  end

  assign phiTick_nxt = running & (phase_nxt == 3'h0);

  // Divide mask per select code; 11X falls back to full speed
  always_comb begin
    unique case (bmAct_r)
      3'h1:    busMask = 5'h01;
      3'h2:    busMask = 5'h03;
      3'h3:    busMask = 5'h07;
      3'h4:    busMask = 5'h0f;
      3'h5:    busMask = 5'h1f;
      default: busMask = 5'h00;
    endcase
  end

  assign busEnd     = ((busCnt_r & busMask) == busMask);
  assign busCnt_nxt = busEnd ? 5'h00 : (busCnt_r + 5'h01);

  // Counters; selection changes only at a bus period end so no short pulse
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_r  <= 3'h0;
      busCnt_r <= 5'h00;
      bmAct_r  <= `PLLCG_RST_BMSEL;
    end else begin
      phase_r <= phase_nxt;
      if (phiTick_nxt) begin
        busCnt_r <= busCnt_nxt;
        if (busEnd) begin
          bmAct_r <= bmSel_r;
        end
      end
    end
  end

  // Output flops; the pin idles high whenever the clock is stopped
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phiTick_r <= 1'b0;
      busTick_r <= 1'b0;
      phiPin_r  <= 1'b1;
      phiOe_r   <= 1'b0;
      running_r <= 1'b0;
    end else begin
      phiTick_r <= phiTick_nxt;
      busTick_r <= phiTick_nxt & busEnd;
      phiPin_r  <= ~running | pinOff_r | (phase_nxt <= (phaseLast >> 1));
      phiOe_r   <= hwStb;
      running_r <= running;
    end
  end

  assign axiRsp       = axiRsp_r;
  assign phiTick      = phiTick_r;
  assign busTick      = busTick_r;
  assign phiPinOut    = phiPin_r;
  assign phiPinOe     = phiOe_r;
  assign clockRunning = running_r;
  assign activeMult   = multAct_r;
  assign breakStart   = breakStart_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_pin_high_stopped;
    @(posedge clk) disable iff (!rst_b) !running |=> phiPinOut;
  endproperty
  a_pin_high_stopped: assert property (p_pin_high_stopped) else $error("clock pin not high while stopped");

  property p_pin_off;
    @(posedge clk) disable iff (!rst_b) pinOff_r ##1 pinOff_r |-> phiPinOut;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("clock pin toggles with output off");

  property p_pin_float;
    @(posedge clk) disable iff (!rst_b) hwStb |=> phiPinOe ##1 !clockRunning;
  endproperty
  a_pin_float: assert property (p_pin_float) else $error("clock pin driven in hardware standby");

  property p_rsv_zero;
    @(posedge clk) disable iff (!rst_b) axiRsp.rvalid |-> (axiRsp.rdata[6:4] == 3'h0);
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits read nonzero");

  property p_defer;
    @(posedge clk) disable iff (!rst_b) (running && !swMode_r && !standbyEnter) |=> $stable(activeMult);
  endproperty
  a_defer: assert property (p_defer) else $error("multiplier changed without standby");

  property p_immediate;
    @(posedge clk) disable iff (!rst_b)
      (multPend_r && swMode_r && running && !wrLp) ##1 (swMode_r && running && !wrLp)[*8] |-> !multPend_r;
  endproperty
  a_immediate: assert property (p_immediate) else $error("immediate multiplier not applied");

  property p_adopt;
    @(posedge clk) disable iff (!rst_b)
      (running && standbyEnter && !hwStb) |=> (state_r == ST_STOP) && (activeMult == $past(multReq_r));
  endproperty
  a_adopt: assert property (p_adopt) else $error("standby entry did not adopt multiplier");

  property p_wait;
    @(posedge clk) disable iff (!rst_b)
      (state_r == ST_STOP) ##1 (state_r == ST_WAIT) |-> (!clockRunning && !phiTick)[*8];
  endproperty
  a_wait: assert property (p_wait) else $error("clock resumed before wait time");

  property p_break;
    @(posedge clk) disable iff (!rst_b) breakStart |-> ($past(state_r) == ST_WAIT) && (state_r == ST_RUN);
  endproperty
  a_break: assert property (p_break) else $error("break started outside wait end");

  property p_align;
    @(posedge clk) disable iff (!rst_b) (extRise && running) |=> phiTick;
  endproperty
  a_align: assert property (p_align) else $error("phase not aligned to external edge");

  property p_bus_sub;
    @(posedge clk) disable iff (!rst_b) !(phiTick_nxt && busEnd) |=> $stable(bmAct_r);
  endproperty
  a_bus_sub: assert property (p_bus_sub) else $error("bus clock select changed inside a period");

  c_deferred: cover property (@(posedge clk) disable iff (!rst_b) (state_r == ST_WAIT) ##1 (state_r == ST_RUN));
  c_break:    cover property (@(posedge clk) disable iff (!rst_b) breakStart);
  c_imm:      cover property (@(posedge clk) disable iff (!rst_b) (multPend_r && swMode_r) ##1 !multPend_r);
  c_div32:    cover property (@(posedge clk) disable iff (!rst_b) busTick && (bmAct_r == 3'h5));
endmodule : pllcg_top
`default_nettype wire

// *** testbench/test_pll_clock_generator_control.sv ***
// Self-checking bench for the clock generator control: register bus, multiplier, bus clock, pin, standby
`timescale 1ns/1ps
`default_nettype none
`include "pllcg_regs.svh"
module test_pll_clock_generator_control;
  import pllcg_pkg::*;
  logic                  clk;
  logic                  rst_b;
  pllcg_axi_req_s        axiReq;
  pllcg_axi_rsp_s        axiRsp;
  logic                  hwStandbyPin;
  logic                  standbyEnter;
  logic                  standbyRelease;
  logic                  pcBreakOnSleep;
  logic [2:0]            standbyWaitSelect;
  logic                  phiTick;
  logic                  busTick;
  logic                  phiPinOut;
  logic                  phiPinOe;
  logic                  clockRunning;
  logic [1:0]            activeMult;
  logic                  breakStart;
  logic                  extClkPin;
  logic [2:0]            extCnt;
  logic [3:0]            strb;
  logic [5:0]            obs;
  int                    fail_count;
  int                    check_count;
  int                    cycles;
  int                    n;
  logic [31:0]           rd;
  logic [1:0]            resp;
  // ----------------------------------------
  // Clock, reset and device
  // ----------------------------------------
  initial clk = 1'b0;
  always #12.5 clk = ~clk;
  // Oscillator at clk/8, parked high while the generator is stopped
  always @(posedge clk) extCnt <= extCnt + 3'h1;
  assign extClkPin = extCnt[2] | ~clockRunning;
  assign obs = {~phiPinOut, breakStart, clockRunning, busTick, phiTick, phiPinOe};
  // Oscillator runs in step with the x1 period, so restarts only shorten the first period
  pllcg_top dut (.clk(clk), .rst_b(rst_b), .axiReq(axiReq), .axiRsp(axiRsp), .extClkPin(extClkPin),
    .hwStandbyPin(hwStandbyPin), .standbyEnter(standbyEnter), .standbyRelease(standbyRelease),
    .pcBreakOnSleep(pcBreakOnSleep), .standbyWaitSelect(standbyWaitSelect), .phiTick(phiTick),
    .busTick(busTick), .phiPinOut(phiPinOut), .phiPinOe(phiPinOe), .clockRunning(clockRunning),
    .activeMult(activeMult), .breakStart(breakStart));
  // ----------------------------------------
  // Reporting
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  // Hang guard well above the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      fail_count++;
      report_and_stop();
    end
  end
  // ----------------------------------------
  // Bus and wait helpers
  // ----------------------------------------
  task automatic axiWrite(input logic [31:0] addr, input logic [31:0] data, output logic [1:0] bresp);
    logic awDone;
    logic wDone;
    awDone = 1'b0;
    wDone = 1'b0;
    axiReq.awvalid <= 1'b1; axiReq.awaddr <= addr; axiReq.wvalid <= 1'b1;
    axiReq.wdata <= data; axiReq.wstrb <= strb; axiReq.bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (!awDone && axiRsp.awready) begin awDone = 1'b1; axiReq.awvalid <= 1'b0; end
      if (!wDone && axiRsp.wready) begin wDone = 1'b1; axiReq.wvalid <= 1'b0; end
      if (axiRsp.bvalid) begin bresp = axiRsp.bresp; axiReq.bready <= 1'b0; break; end
    end
    @(posedge clk);
  endtask : axiWrite
  task automatic axiRead(input logic [31:0] addr, output logic [31:0] data, output logic [1:0] rresp);
    axiReq.arvalid <= 1'b1; axiReq.araddr <= addr; axiReq.rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (axiReq.arvalid && axiRsp.arready) axiReq.arvalid <= 1'b0;
      if (axiRsp.rvalid) begin data = axiRsp.rdata; rresp = axiRsp.rresp; axiReq.rready <= 1'b0; break; end
    end
    @(posedge clk);
  endtask : axiRead
  // Wait for one observed flag, bounded; count of edges returned
  task automatic waitObs(input int idx, input int limit, output int cnt);
    cnt = 0;
    do begin @(posedge clk); cnt++; end while (obs[idx] !== 1'b1 && cnt < limit);
  endtask : waitObs
  // Period of a tick, measured between two of them
  task automatic period(input int idx, output int cnt);
    waitObs(idx, 200, cnt);
    waitObs(idx, 200, cnt);
  endtask : period
  task automatic regCheck(input logic [31:0] addr, input logic [31:0] wv, input logic [31:0] exp);
    axiWrite(addr, wv, resp);
    check(resp, `PLLCG_RESP_OKAY);
    axiRead(addr, rd, resp);
    check(rd, exp);
  endtask : regCheck
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_b = 1'b0; axiReq = '0; hwStandbyPin = 1'b0; standbyEnter = 1'b0; standbyRelease = 1'b0;
    pcBreakOnSleep = 1'b0; standbyWaitSelect = 3'h0; fail_count = 0; check_count = 0; cycles = 0;
    extCnt = 3'h0;
    strb = 4'hf;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    // Reset values and reserved bits
    axiRead(`PLLCG_ADDR_SYSCLK, rd, resp); check(rd, 32'h0000_0000);
    axiRead(`PLLCG_ADDR_LPWR, rd, resp); check(rd, 32'h0000_0000);
    check(activeMult, `PLLCG_MULT_X1);
    period(1, n); check(n, 8);
    regCheck(`PLLCG_ADDR_SYSCLK, 32'h0000_0070, 32'h0000_0000);
    regCheck(`PLLCG_ADDR_LPWR, 32'h0000_000c, 32'h0000_000c);
    regCheck(`PLLCG_ADDR_LPWR, 32'h0000_0000, 32'h0000_0000);
    axiWrite(32'h0000_0010, 32'h0000_00ff, resp); check(resp, `PLLCG_RESP_SLVERR);
    axiRead(32'h0000_0010, rd, resp); check(resp, `PLLCG_RESP_SLVERR);
    // Byte lane 0 off: write is dropped but still answered OKAY
    strb = 4'h0;
    axiWrite(`PLLCG_ADDR_SYSCLK, 32'h0000_0087, resp); check(resp, `PLLCG_RESP_OKAY);
    strb = 4'hf;
    axiRead(`PLLCG_ADDR_SYSCLK, rd, resp); check(rd, 32'h0000_0000);
    $display("Test registers done");
    // Pin toggles, then held high with output off
    waitObs(5, 20, n); check(obs[5], 1'b1);
    regCheck(`PLLCG_ADDR_SYSCLK, 32'h0000_00f8, 32'h0000_0088);
    waitObs(5, 40, n); check(obs[5], 1'b0);
    axiWrite(`PLLCG_ADDR_SYSCLK, 32'h0000_0008, resp);
    $display("Test clock pin done");
    // Immediate multiplier switching
    axiWrite(`PLLCG_ADDR_LPWR, 32'h0000_0001, resp);
    repeat (10) @(posedge clk);
    check(activeMult, `PLLCG_MULT_X2);
    period(1, n); check(n, 4);
    axiWrite(`PLLCG_ADDR_LPWR, 32'h0000_0002, resp);
    repeat (10) @(posedge clk);
    check(activeMult, `PLLCG_MULT_X4);
    period(1, n); check(n, 2);
    $display("Test immediate switch done");
    // Bus master clock divider, one code at a time
    for (int k = 0; k < 6; k++) begin
      axiWrite(`PLLCG_ADDR_SYSCLK, 32'(8 + k), resp);
      waitObs(2, 200, n);
      period(2, n); check(n, 2 << k);
    end
    $display("Test bus clock done");
    // Deferred switch through software standby with break armed
    axiWrite(`PLLCG_ADDR_SYSCLK, 32'h0000_0000, resp);
    standbyWaitSelect <= 3'h1;
    axiWrite(`PLLCG_ADDR_LPWR, 32'h0000_0000, resp);
    repeat (20) @(posedge clk);
    check(activeMult, `PLLCG_MULT_X4);
    pcBreakOnSleep <= 1'b1;
    standbyEnter <= 1'b1;
    @(posedge clk);
    standbyEnter <= 1'b0;
    repeat (3) @(posedge clk);
    check(activeMult, `PLLCG_MULT_X1);
    check({clockRunning, phiPinOut, phiPinOe}, 3'b010);
    waitObs(1, 30, n); check(n, 30);
    standbyRelease <= 1'b1;
    @(posedge clk);
    standbyRelease <= 1'b0;
    repeat (100) @(posedge clk);
    check(clockRunning, 1'b0);
    waitObs(4, 60, n); check(breakStart, 1'b1);
    repeat (2) @(posedge clk);
    check(clockRunning, 1'b1);
    // Give the phase time to relock to the oscillator after the parked pin
    repeat (24) @(posedge clk);
    period(1, n); check(n, 8);
    pcBreakOnSleep <= 1'b0;
    $display("Test deferred switch done");
    // Hardware standby floats the pin, release goes through the wait
    hwStandbyPin <= 1'b1;
    waitObs(0, 10, n); check(phiPinOe, 1'b1);
    repeat (2) @(posedge clk);
    check(clockRunning, 1'b0);
    standbyWaitSelect <= 3'h0;
    hwStandbyPin <= 1'b0;
    waitObs(3, 90, n); check(clockRunning, 1'b1);
    check(phiPinOe, 1'b0);
    $display("Test hardware standby done");
    report_and_stop();
  end
endmodule : test_pll_clock_generator_control
`default_nettype wire
